// ---- core/grc_core.sv ----
// multi-port 1000 Mb/s half-duplex repeater core
// Functional notes
// - a frame from one port goes out of every other port and never back out of its own.
// - a received code violation goes to every transmitting port as an explicit error code-group.
// - after a code violation the rest of that packet is sent as error code elements on every other port.
// - every receive event on any port is detected, whatever its kind.
// - every received signal is repeated, well-formed frame or not.
// - the sent preamble differs from the received one by at most 8 bit times.
// - start_of_packet_delay plus start_of_jam_delay stays within 976 bit times.
// - start_of_packet_delay varies by at most 16 bit times between packets.
// - activity on more than one port at once is a collision.
// - jam goes out on all ports for as long as the collision lasts.
// - end_of_jam_delay is no greater than start_of_packet_delay.
`timescale 1ns/1ps
`include "grc_map.svh"
module grc_core
    import grc_pkg::*;
#(
    parameter int NPORTS = 4
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire grc_rx_type [NPORTS-1:0] rx_i,
    output grc_tx_type [NPORTS-1:0] tx_o,
    output logic collision_o,
    output logic [NPORTS-1:0] active_o
);
    localparam int IW = $clog2(NPORTS);
    localparam int SOP_CYC = `GRC_PIPE_CYCLES;
    localparam int SOJ_CYC = `GRC_PIPE_CYCLES;
    localparam int SOP_BT = SOP_CYC * `GRC_BT_PER_CYCLE;
    localparam int SOJ_BT = SOJ_CYC * `GRC_BT_PER_CYCLE;
    // fixed two-cycle pipeline keeps both delays far below the combined budget
    localparam int BUDGET_BT = SOP_BT + SOJ_BT;

    grc_rx_type [NPORTS-1:0] rx_q;
    logic [NPORTS-1:0] act_q;
    logic any_act;
    logic multi_act;
    logic [IW-1:0] src;
    logic [IW-1:0] src_q;
    grc_rx_type sel_rx;
    logic single_act;
    logic err_latch;
    logic next_err_latch;
    logic err_now;
    grc_mode_type mode;
    grc_mode_type next_mode;
    grc_tx_type [NPORTS-1:0] next_tx;

    genvar gp;
    generate
        for (gp = 0; gp < NPORTS; gp++) begin : g_port
            // relies on the PHY not reflecting our transmit as carrier
            grc_port_rx u_rx (
                .mclk_i(mclk_i),
                .rst_b_i(rst_b_i),
                .rx_i(rx_i[gp]),
                .rx_q_o(rx_q[gp]),
                .active_o(act_q[gp])
            );
        end
    endgenerate

    grc_arbiter #(
        .NPORTS(NPORTS),
        .IW(IW)
    ) u_arb (
        .active_i(act_q),
        .any_o(any_act),
        .multi_o(multi_act),
        .src_o(src)
    );

    assign sel_rx = rx_q[src];
    assign single_act = any_act & ~multi_act;
    // error marking: a violation now or earlier in this packet
    assign err_now = sel_rx.rx_dv & (sel_rx.rx_er | err_latch);

    // held until the packet ends; a collision also spoils what follows
    assign next_err_latch = multi_act | (single_act & sel_rx.rx_dv & (err_latch | sel_rx.rx_er));

    always_comb begin
        if (multi_act) begin
            next_mode = GRC_JAM;
        end else if (any_act) begin
            next_mode = GRC_FWD;
        end else begin
            next_mode = GRC_IDLE;
        end
    end

    always_comb begin
        for (int p = 0; p < NPORTS; p++) begin
            next_tx[p] = '{txd: `GRC_IDLE_OCTET, tx_en: 1'b0, tx_er: 1'b0};
            unique case (next_mode)
                GRC_JAM: begin
                    next_tx[p] = '{txd: `GRC_JAM_OCTET, tx_en: 1'b1, tx_er: 1'b0};
                end
                GRC_FWD: begin
                    if (IW'(p) != src) begin
                        // octets copied one for one, preamble included
                        next_tx[p].txd = err_now ? `GRC_ERR_OCTET : sel_rx.rxd;
                        next_tx[p].tx_en = sel_rx.rx_dv;
                        next_tx[p].tx_er = sel_rx.rx_er | err_now;
                    end
                end
                GRC_IDLE: begin
                end
                default: begin
                end
            endcase
        end
    end

    // same latency for every packet and for jam
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_o <= '0;
        end else begin
            tx_o <= next_tx;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode <= GRC_IDLE;
            collision_o <= 1'b0;
        end else begin
            mode <= next_mode;
            collision_o <= multi_act;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            err_latch <= 1'b0;
        end else begin
            err_latch <= next_err_latch;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            src_q <= '0;
        end else begin
            src_q <= src;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            active_o <= '0;
        end else begin
            active_o <= act_q;
        end
    end

    // checking helpers
    logic [IW-1:0] dst;
    logic [IW-1:0] dst_q;
    logic [NPORTS-1:0] jam_ok;
    logic [NPORTS-1:0] rx_evt_in;
    logic any_in;

    assign dst = (src == '0) ? IW'(1) : '0;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dst_q <= '0;
        end else begin
            dst_q <= dst;
        end
    end

    always_comb begin
        for (int p = 0; p < NPORTS; p++) begin
            jam_ok[p] = tx_o[p].tx_en & (tx_o[p].txd == `GRC_JAM_OCTET) & ~tx_o[p].tx_er;
            rx_evt_in[p] = rx_i[p].crs | rx_i[p].rx_dv | rx_i[p].rx_er;
        end
    end
    assign any_in = |rx_evt_in;

    sequence s_single_clean;
        single_act && !err_now;
    endsequence

    sequence s_violation;
        single_act && sel_rx.rx_dv && sel_rx.rx_er;
    endsequence

    sequence s_start;
        !any_in ##1 any_in;
    endsequence

    AST_NO_ECHO: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        mode == GRC_FWD |-> !tx_o[src_q].tx_en && !tx_o[src_q].tx_er)
        else $error("frame sent back out of its receiving port");

    AST_FWD_DATA: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        s_single_clean |=> tx_o[dst_q].txd == $past(sel_rx.rxd)
            && tx_o[dst_q].tx_en == $past(sel_rx.rx_dv)
            && tx_o[dst_q].tx_er == $past(sel_rx.rx_er))
        else $error("received octet not repeated unchanged");

    AST_VIOL_MARK: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        s_violation |=> tx_o[dst_q].tx_en && tx_o[dst_q].tx_er && err_latch)
        else $error("code violation not sent as error code-group");

    AST_ERR_HOLD: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        s_violation ##1 (single_act && sel_rx.rx_dv)
            |=> tx_o[dst_q].tx_er && tx_o[dst_q].txd == `GRC_ERR_OCTET)
        else $error("rest of packet not substituted after violation");

    AST_DETECT: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        s_start |-> ##SOP_CYC mode != GRC_IDLE && $past(mode) == GRC_IDLE)
        else $error("receive event not picked up at the fixed delay");

    AST_COLL: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        multi_act |=> mode == GRC_JAM && collision_o && (&jam_ok))
        else $error("collision not jammed on every port");

    AST_JAM_LASTS: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        multi_act [*2] |=> (&jam_ok) [*1] ##0 $past(collision_o))
        else $error("jam dropped during collision");

    AST_EOJ: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        $fell(multi_act) |=> mode != GRC_JAM && !collision_o)
        else $error("jam outlasts the collision");

    AST_IDLE_QUIET: assert property (
        @(posedge mclk_i) disable iff (!rst_b_i)
        !any_act |=> (mode == GRC_IDLE) && !(|active_o) && !collision_o)
        else $error("output activity without any receive event");
endmodule // grc_core

// ---- core/grc_map.svh ----
// timing and code constants of the gigabit repeater core
`ifndef GRC_MAP_SVH
`define GRC_MAP_SVH
`define GRC_BT_PER_CYCLE 8
`define GRC_SOP_SOJ_MAX_BT 976
`define GRC_SOP_VAR_MAX_BT 16
`define GRC_PRE_VAR_MAX_BT 8
`define GRC_PIPE_CYCLES 2
`define GRC_SOP_SOJ_MAX_CYC (`GRC_SOP_SOJ_MAX_BT / `GRC_BT_PER_CYCLE)
`define GRC_JAM_OCTET 8'h55
`define GRC_ERR_OCTET 8'h0f
`define GRC_IDLE_OCTET 8'h00
`endif

// ---- core/grc_pkg.sv ----
// types of the gigabit repeater core
package grc_pkg;
    typedef struct packed {
        logic [7:0] rxd;
        logic rx_dv;
        logic rx_er;
        logic crs;
    } grc_rx_type;

    typedef struct packed {
        logic [7:0] txd;
        logic tx_en;
        logic tx_er;
    } grc_tx_type;

    typedef enum logic [1:0] {
        GRC_IDLE = 2'b00,
        GRC_FWD = 2'b01,
        GRC_JAM = 2'b11
    } grc_mode_type;
endpackage

// ---- core/grc_port_rx.sv ----
// one port's receive register and event detect
`timescale 1ns/1ps
module grc_port_rx
    import grc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire grc_rx_type rx_i,
    output grc_rx_type rx_q_o,
    output logic active_o
);
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_q_o <= '0;
            active_o <= 1'b0;
        end else begin
            rx_q_o <= rx_i;
            // any carrier, data or error counts, whatever its kind
            active_o <= rx_i.crs | rx_i.rx_dv | rx_i.rx_er;
        end
    end
endmodule // grc_port_rx

// ---- core/grc_arbiter.sv ----
// finds the receiving port and flags more than one
`timescale 1ns/1ps
module grc_arbiter #(
    parameter int NPORTS = 4,
    parameter int IW = $clog2(NPORTS)
) (
    input wire logic [NPORTS-1:0] active_i,
    output logic any_o,
    output logic multi_o,
    output logic [IW-1:0] src_o
);
    always_comb begin
        any_o = 1'b0;
        multi_o = 1'b0;
        src_o = '0;
        for (int p = 0; p < NPORTS; p++) begin
            if (active_i[p]) begin
                if (any_o) begin
                    multi_o = 1'b1;
                end
                any_o = 1'b1;
                src_o = IW'(p);
            end
        end
    end
endmodule // grc_arbiter

// ---- bench/grc_phy_model.sv ----
// attached port entity feeding one repeater port
`timescale 1ns/1ps
module grc_phy_model
    import grc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire grc_rx_type req_i,
    input wire grc_tx_type tx_i,
    output grc_rx_type rx_o
);
    logic [7:0] stale;

    // idle data lines wander so a stale octet never looks valid
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stale <= 8'ha5;
        end else begin
            stale <= ~rx_o.rxd;
        end
    end

    // carrier follows line activity only, never our own transmit
    always_comb begin
        rx_o = req_i;
        rx_o.crs = req_i.crs;
        if (!(req_i.rx_dv | req_i.rx_er | req_i.crs)) begin
            rx_o.rxd = stale;
        end
    end
endmodule // grc_phy_model

// ---- bench/test_gigabit_repeater_core.sv ----
// self-checking bench of the repeater core
`timescale 1ns/1ps
`include "grc_map.svh"
module test_gigabit_repeater_core;
    import grc_pkg::*;
    localparam int NP = 4;
    logic mclk;
    logic rst_b;
    grc_rx_type [NP-1:0] req;
    wire grc_rx_type [NP-1:0] rx;
    grc_tx_type [NP-1:0] tx;
    logic coll;
    logic [NP-1:0] act;
    grc_tx_type [NP-1:0] e1, e2;
    logic [NP-1:0] a1, a2;
    logic c1, c2, lat;
    int err_count = 0;
    int n_checks = 0;

    grc_core #(.NPORTS(NP)) u_grc_core (.mclk_i(mclk), .rst_b_i(rst_b), .rx_i(rx), .tx_o(tx),
        .collision_o(coll), .active_o(act));

    for (genvar p = 0; p < NP; p++) begin : g_phy
        grc_phy_model u_grc_phy_model (.mclk_i(mclk), .rst_b_i(rst_b), .req_i(req[p]), .tx_i(tx[p]),
            .rx_o(rx[p]));
    end

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // expected outputs, two octet cycles behind the sampled inputs
    always @(posedge mclk or negedge rst_b) begin : ref_model
        grc_tx_type [NP-1:0] t;
        logic [NP-1:0] a;
        int n;
        int s;
        logic bad;
        if (!rst_b) begin
            e1 <= '0;
            e2 <= '0;
            a1 <= '0;
            a2 <= '0;
            c1 <= 1'b0;
            c2 <= 1'b0;
            lat <= 1'b0;
        end else begin
            n = 0;
            s = 0;
            for (int p = 0; p < NP; p++) begin
                a[p] = rx[p].crs | rx[p].rx_dv | rx[p].rx_er;
                if (a[p]) begin
                    n++;
                    s = p;
                end
            end
            bad = lat | (rx[s].rx_dv & rx[s].rx_er);
            for (int p = 0; p < NP; p++) begin
                if (n > 1) t[p] = {`GRC_JAM_OCTET, 1'b1, 1'b0};
                else if (n == 0 || p == s) t[p] = '0;
                else if (bad && rx[s].rx_dv) t[p] = {`GRC_ERR_OCTET, 1'b1, 1'b1};
                else t[p] = {rx[s].rxd, rx[s].rx_dv, rx[s].rx_er};
            end
            lat <= (n > 1) || ((n == 1) && rx[s].rx_dv && bad);
            e1 <= t;
            e2 <= e1;
            a1 <= a;
            a2 <= a1;
            c1 <= (n > 1);
            c2 <= c1;
        end
    end

    task automatic chk_tx(input string what, input grc_tx_type exp, input grc_tx_type got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic chk_f(input string what, input logic [NP-1:0] exp, input logic [NP-1:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) begin
            @(negedge mclk);
            for (int p = 0; p < NP; p++) begin
                chk_tx($sformatf("tx%0d", p), e2[p], tx[p]);
            end
            chk_f("collision", {3'b000, c2}, {3'b000, coll});
            chk_f("active", a2, act);
        end
    endtask

    // preamble, delimiter, data; bad_at marks one code violation
    task automatic frame(input int p, input int len, input int bad_at);
        for (int i = 0; i < len; i++) begin
            req[p] = {(i < 7) ? 8'h55 : (i == 7) ? 8'hd5 : 8'(i * 19), 1'b1, i == bad_at, 1'b1};
            step(1);
        end
        req[p] = '0;
        step(1);
    endtask

    task automatic t_frames();
        for (int p = 0; p < NP; p++) frame(p, 12, -1);
        step(2);
        $display("t_frames done errors %0d", err_count);
    endtask

    task automatic t_violation();
        frame(1, 14, 9);
        frame(2, 10, 9);
        frame(0, 10, -1);
        step(2);
        $display("t_violation done errors %0d", err_count);
    endtask

    task automatic t_carrier();
        req[3] = {8'h0e, 1'b0, 1'b0, 1'b1};
        step(3);
        req[3] = {8'h1f, 1'b0, 1'b1, 1'b1};
        step(3);
        req[3] = '0;
        step(3);
        $display("t_carrier done errors %0d", err_count);
    endtask

    task automatic t_collision();
        req[0] = {8'h55, 1'b1, 1'b0, 1'b1};
        step(4);
        req[2] = {8'h55, 1'b1, 1'b0, 1'b1};
        step(3);
        req[1] = {8'h0e, 1'b0, 1'b0, 1'b1};
        step(2);
        req[1] = '0;
        req[2] = '0;
        req[0] = {8'h3c, 1'b1, 1'b0, 1'b1};
        step(4);
        req[0] = '0;
        step(3);
        $display("t_collision done errors %0d", err_count);
    endtask

    task automatic t_reset();
        req[1] = {8'h55, 1'b1, 1'b0, 1'b1};
        step(3);
        rst_b = 1'b0;
        step(3);
        rst_b = 1'b1;
        step(2);
        req[1] = '0;
        step(3);
        $display("t_reset done errors %0d", err_count);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        results();
    end

    initial begin
        req = '0;
        rst_b = 1'b0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'b1;
        step(2);
        t_frames();
        t_violation();
        t_carrier();
        t_collision();
        t_reset();
        results();
    end
endmodule // test_gigabit_repeater_core
